// ==== hw/pts_pkg.sv ====
// Purpose: shared constants and types for the time-data/status slice
// Assumes: 16-bit management data, 5-bit register address
// Notes: offsets are register indices on the time-sync page
package pts_pkg;
   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam int AW = 5;
   localparam int DW = 16;
   localparam logic [AW-1:0] A_TDR = 5'h15;
   localparam logic [AW-1:0] A_STS = 5'h16;
   localparam logic [AW-1:0] A_TSTS = 5'h17;
   localparam logic [DW-1:0] ZERO16 = 16'h0000;

   // -----------------------------------------------------------------
   // status register fields
   // -----------------------------------------------------------------
   localparam int B_TXRDY = 11;
   localparam int B_RXRDY = 10;
   localparam int B_FIRED = 9;
   localparam int B_EVRDY = 8;
   localparam int B_IE_HI = 3;
   localparam int B_TXIE = 3;
   localparam int B_RXIE = 2;
   localparam int B_TRIE = 1;
   localparam int B_EVIE = 0;
   localparam logic [3:0] IE_RST = 4'h0;

   // -----------------------------------------------------------------
   // time-data sequencing
   // -----------------------------------------------------------------
   localparam int NTRIG = 8;
   localparam int SELW = 3;
   localparam int PTRW = 3;
   localparam logic [PTRW-1:0] CLK_WORDS = 3'h4;
   localparam logic [PTRW-1:0] TRIG_WORDS = 3'h6;
   localparam logic [PTRW-1:0] PTR_ONE = 3'h1;
   localparam logic [PTRW-1:0] PTR_RST = 3'h0;

   // register port request
   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic wr;
      logic rd;
   } pts_bus_t;

   // one-cycle command strobes from the command register
   typedef struct packed {
      logic [SELW-1:0] sel;
      logic trig_rd;
      logic trig_ld;
      logic trig_en;
      logic trig_dis;
      logic clk_smp;
      logic clk_set;
   } pts_cmd_t;

   // what the time-data port is bound to
   typedef enum logic [2:0] {
      M_CLK = 3'h1,
      M_TRD = 3'h2,
      M_TWR = 3'h4
   } pts_mode_t;
endpackage

// ==== hw/pts_regs.sv ====
// Purpose: time-data port, sync status and trigger status registers
// Assumes: command strobes and engine status are synchronous to i_clk
// Notes: read data appears the cycle after the read strobe
//
// Contract
// R1: command strobes decide whether the port carries clock or trigger words
// R2: each port read returns the next 16-bit word of the selected value
// R3: reads past the last field return zero
// R4: each port write stores the next 16-bit field in sequence
// R5: status bits 15:12 and 7:4 ignore writes and read zero
// R6: bit 11 follows transmit stamp availability from the stamp queue
// R7: bit 10 follows receive stamp availability from the stamp queue
// R8: bit 9 sets on a trigger firing, clears when status is read
// R9: bit 9 sets only for triggers with notification enabled
// R10: bit 8 follows event stamp availability from the event queue
// R11: bits 3 and 2 are read-write tx and rx interrupt enables
// R12: bits 1 and 0 are read-write trigger and event interrupt enables
// R13: trigger n active flag at bit 2n, error flag at bit 2n+1
// R14: active flag reads one while trigger enabled and not completed
// R15: error flag sets when a trigger was programmed in the past
// R16: error flag clears when trigger disabled or re-armed
// R17: error flags set only for triggers with notification enabled
// R18: after trigger-read, port reads return that trigger's fields
// R19: trigger-load disables the trigger; port writes fill its fields
// R20: clock-sample captures current time for reading through the port
// R21: clock-set loads the clock from previously written port words
// R22: interrupt request while any flag is set with its enable
// R23: any read, load or sample command restarts the field pointer
`timescale 1ns/100ps
module pts_regs (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // register port
   input wire pts_pkg::pts_bus_t i_bus,
   output logic [pts_pkg::DW-1:0] o_rdata,
   // command strobes
   input wire pts_pkg::pts_cmd_t i_cmd,
   // clock engine
   input wire logic [63:0] i_clk_time,
   output logic o_clk_set,
   output logic [63:0] o_clk_set_val,
   // stamp queues
   input wire logic i_tx_avail,
   input wire logic i_rx_avail,
   input wire logic i_ev_avail,
   // trigger engine
   input wire logic [pts_pkg::NTRIG-1:0] i_trig_fire,
   input wire logic [pts_pkg::NTRIG-1:0] i_trig_late,
   input wire logic [pts_pkg::NTRIG-1:0] i_trig_active,
   input wire logic [pts_pkg::NTRIG-1:0] i_trig_notify,
   output logic o_trig_wr,
   output logic [pts_pkg::SELW-1:0] o_trig_widx,
   output logic [pts_pkg::PTRW-1:0] o_trig_wfield,
   output logic [pts_pkg::DW-1:0] o_trig_wdata,
   output logic o_trig_disable,
   output logic [pts_pkg::SELW-1:0] o_trig_dis_idx,
   // interrupt
   output logic o_irq
);
   localparam int NT = pts_pkg::NTRIG;
   localparam int TW = 6;
   localparam int SW = pts_pkg::SELW;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   pts_pkg::pts_mode_t mode_r, mode_nxt;
   logic [pts_pkg::SELW-1:0] sel_r, sel_nxt;
   logic [pts_pkg::PTRW-1:0] rd_ptr_r, rd_ptr_nxt;
   logic [pts_pkg::PTRW-1:0] wr_ptr_r, wr_ptr_nxt;
   logic [3:0][15:0] snap_r;
   logic [3:0][15:0] load_r;
   logic [15:0] tmem [NT][TW];
   logic fired_r, fired_nxt;
   logic [3:0] ie_r, ie_nxt;
   logic [NT-1:0] err_r, err_nxt;
   logic [15:0] rdata_nxt;

   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   wire rd_tdr = i_bus.rd && (i_bus.addr == pts_pkg::A_TDR);
   wire rd_sts = i_bus.rd && (i_bus.addr == pts_pkg::A_STS);
   wire rd_tsts = i_bus.rd && (i_bus.addr == pts_pkg::A_TSTS);
   wire wr_tdr = i_bus.wr && (i_bus.addr == pts_pkg::A_TDR);
   wire wr_sts = i_bus.wr && (i_bus.addr == pts_pkg::A_STS);
   // commands that rebind the port and restart the pointers
   wire any_cmd = i_cmd.trig_rd | i_cmd.trig_ld | i_cmd.clk_smp
      | i_cmd.clk_set; // [R23]
   // a trigger load ends on its last field or on an enable
   wire ld_last = (mode_r == pts_pkg::M_TWR) && wr_tdr
      && (wr_ptr_r == pts_pkg::TRIG_WORDS - pts_pkg::PTR_ONE);
   wire ld_end = ld_last
      || ((mode_r == pts_pkg::M_TWR) && i_cmd.trig_en);
   wire [pts_pkg::PTRW-1:0] rd_lim = (mode_r == pts_pkg::M_TRD)
      ? pts_pkg::TRIG_WORDS : pts_pkg::CLK_WORDS; // [R1]
   wire [pts_pkg::PTRW-1:0] wr_lim = (mode_r == pts_pkg::M_TWR)
      ? pts_pkg::TRIG_WORDS : pts_pkg::CLK_WORDS;
   wire rd_more = rd_ptr_r < rd_lim;
   wire wr_more = wr_ptr_r < wr_lim;
   wire [15:0] tdr_word = !rd_more ? pts_pkg::ZERO16 // [R3]
      : (mode_r == pts_pkg::M_TRD) ? tmem[sel_r][rd_ptr_r] // [R18]
      : (mode_r == pts_pkg::M_CLK) ? snap_r[rd_ptr_r[1:0]] // [R2]
      : pts_pkg::ZERO16;

   // -----------------------------------------------------------------
   // status and trigger status composition
   // -----------------------------------------------------------------
   wire [NT-1:0] fire_ok = i_trig_fire & i_trig_notify; // [R9]
   wire fire_set = |fire_ok;
   wire [NT-1:0] late_ok = i_trig_late & i_trig_notify; // [R15] [R17]
   wire [3:0] flags = {i_tx_avail, i_rx_avail, fired_r, i_ev_avail};
   logic [15:0] sts_word;
   logic [15:0] tsts_word;
   logic [NT-1:0] err_clr;

   // reserved bits stay zero; ready bits mirror the queues
   always_comb begin
      sts_word = pts_pkg::ZERO16; // [R5]
      sts_word[pts_pkg::B_TXRDY] = i_tx_avail; // [R6]
      sts_word[pts_pkg::B_RXRDY] = i_rx_avail; // [R7]
      sts_word[pts_pkg::B_FIRED] = fired_r; // [R8]
      sts_word[pts_pkg::B_EVRDY] = i_ev_avail; // [R10]
      sts_word[pts_pkg::B_IE_HI:0] = ie_r; // [R11] [R12]
   end

   // disable, enable and load all re-arm the trigger named in the
   // command itself; the port binding may point at another trigger
   wire cmd_rearm = i_cmd.trig_dis | i_cmd.trig_en | i_cmd.trig_ld;
   wire [pts_pkg::SELW-1:0] cmd_sel = i_cmd.sel;

   // trigger n: active at 2n, error at 2n+1
   genvar g;
   generate
      for (g = 0; g < NT; g++) begin : g_trig
         assign tsts_word[2*g] = i_trig_active[g]; // [R13] [R14]
         assign tsts_word[2*g+1] = err_r[g]; // [R13]
         assign err_clr[g] = (cmd_sel == SW'(g)) && cmd_rearm; // [R16]
      end
   endgenerate

   // -----------------------------------------------------------------
   // next-state logic
   // -----------------------------------------------------------------
   // set wins over clear so a late event is never lost
   always_comb begin
      err_nxt = (err_r & ~err_clr) | late_ok; // [R15] [R16]
      fired_nxt = (fired_r & ~rd_sts) | fire_set; // [R8]
      ie_nxt = wr_sts ? i_bus.wdata[pts_pkg::B_IE_HI:0] : ie_r;
      rdata_nxt = rd_tdr ? tdr_word
         : rd_sts ? sts_word
         : rd_tsts ? tsts_word
         : pts_pkg::ZERO16;
   end

   // port binding and field pointers
   always_comb begin
      mode_nxt = mode_r;
      sel_nxt = sel_r;
      rd_ptr_nxt = rd_ptr_r;
      wr_ptr_nxt = wr_ptr_r;
      if (any_cmd) begin
         rd_ptr_nxt = pts_pkg::PTR_RST; // [R23]
         wr_ptr_nxt = pts_pkg::PTR_RST; // [R23]
         if (i_cmd.trig_ld) begin
            mode_nxt = pts_pkg::M_TWR; // [R19]
            sel_nxt = cmd_sel;
         end else if (i_cmd.trig_rd) begin
            mode_nxt = pts_pkg::M_TRD; // [R18]
            sel_nxt = cmd_sel;
         end else begin
            mode_nxt = pts_pkg::M_CLK; // [R1]
         end
      end else begin
         if (rd_tdr && rd_more)
            rd_ptr_nxt = rd_ptr_r + pts_pkg::PTR_ONE; // [R2]
         if (wr_tdr && wr_more && mode_r != pts_pkg::M_TRD)
            wr_ptr_nxt = wr_ptr_r + pts_pkg::PTR_ONE; // [R4]
         if (ld_end) begin
            mode_nxt = pts_pkg::M_CLK;
            wr_ptr_nxt = pts_pkg::PTR_RST;
         end
      end
   end

   // -----------------------------------------------------------------
   // control registers
   // -----------------------------------------------------------------
   // short flops only; all decisions live above
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         mode_r <= pts_pkg::M_CLK;
         sel_r <= '0;
         rd_ptr_r <= pts_pkg::PTR_RST;
         wr_ptr_r <= pts_pkg::PTR_RST;
         fired_r <= 1'b0;
         ie_r <= pts_pkg::IE_RST;
         err_r <= '0;
         o_rdata <= pts_pkg::ZERO16;
      end else begin
         mode_r <= mode_nxt;
         sel_r <= sel_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         wr_ptr_r <= wr_ptr_nxt;
         fired_r <= fired_nxt;
         ie_r <= ie_nxt;
         err_r <= err_nxt;
         o_rdata <= rdata_nxt;
      end
   end

   // -----------------------------------------------------------------
   // time buffers and trigger field store
   // -----------------------------------------------------------------
   wire clk_wr = wr_tdr && !any_cmd && wr_more
      && (mode_r == pts_pkg::M_CLK);
   wire trg_wr = wr_tdr && !any_cmd && wr_more
      && (mode_r == pts_pkg::M_TWR);

   // snapshot and load words, reset so reads are never unknown
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         snap_r <= '0;
         load_r <= '0;
      end else begin
         if (i_cmd.clk_smp)
            snap_r <= i_clk_time; // [R20]
         if (clk_wr)
            load_r[wr_ptr_r[1:0]] <= i_bus.wdata; // [R4]
      end
   end

   // field store has no reset; read back only after a load
   always_ff @(posedge i_clk) begin
      if (trg_wr)
         tmem[sel_r][wr_ptr_r] <= i_bus.wdata; // [R4] [R19]
   end

   // -----------------------------------------------------------------
   // strobes to the engines
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_clk_set <= 1'b0;
         o_trig_wr <= 1'b0;
         o_trig_widx <= '0;
         o_trig_wfield <= pts_pkg::PTR_RST;
         o_trig_wdata <= pts_pkg::ZERO16;
         o_trig_disable <= 1'b0;
         o_trig_dis_idx <= '0;
      end else begin
         o_clk_set <= i_cmd.clk_set; // [R21]
         o_trig_wr <= trg_wr;
         o_trig_widx <= sel_r;
         o_trig_wfield <= wr_ptr_r;
         o_trig_wdata <= i_bus.wdata;
         o_trig_disable <= i_cmd.trig_ld; // [R19]
         o_trig_dis_idx <= cmd_sel;
      end
   end

   // value stands in flops from the last writes
   assign o_clk_set_val = load_r; // [R21]
   // level, follows flags combinationally
   assign o_irq = |(flags & ie_r); // [R22]

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   sequence s_sample;
      i_cmd.clk_smp ##1 (rd_tdr && !any_cmd);
   endsequence

   property p_rsvd;
      @(posedge i_clk) disable iff (i_rst)
      rd_sts |=> (o_rdata[15:12] == 4'h0 && o_rdata[7:4] == 4'h0);
   endproperty
   a_rsvd: assert property (p_rsvd) // [R5]
      else $error("reserved status bits not zero");

   property p_txrdy;
      @(posedge i_clk) disable iff (i_rst)
      rd_sts |=> (o_rdata[pts_pkg::B_TXRDY] == $past(i_tx_avail)
         && o_rdata[pts_pkg::B_RXRDY] == $past(i_rx_avail));
   endproperty
   a_txrdy: assert property (p_txrdy) // [R6]
      else $error("stamp ready bits wrong");

   property p_fired_clr;
      @(posedge i_clk) disable iff (i_rst)
      rd_sts && !fire_set |=> !fired_r;
   endproperty
   a_fired_clr: assert property (p_fired_clr) // [R8]
      else $error("fired flag not cleared on read");

   property p_fired_set;
      @(posedge i_clk) disable iff (i_rst)
      fire_set |=> fired_r ##1 (fired_r || $past(rd_sts));
   endproperty
   a_fired_set: assert property (p_fired_set) // [R8]
      else $error("fired flag lost");

   property p_no_notify;
      @(posedge i_clk) disable iff (i_rst)
      !fired_r && !fire_set |=> !fired_r;
   endproperty
   a_no_notify: assert property (p_no_notify) // [R9]
      else $error("fired flag set without notify");

   property p_past_end;
      @(posedge i_clk) disable iff (i_rst)
      rd_tdr && !rd_more |=> o_rdata == 16'h0000;
   endproperty
   a_past_end: assert property (p_past_end) // [R3]
      else $error("read past last field not zero");

   property p_ptr_rst;
      @(posedge i_clk) disable iff (i_rst)
      any_cmd |=> (rd_ptr_r == 3'h0 && wr_ptr_r == 3'h0);
   endproperty
   a_ptr_rst: assert property (p_ptr_rst) // [R23]
      else $error("pointer not restarted");

   property p_sample;
      @(posedge i_clk) disable iff (i_rst)
      s_sample |=> o_rdata == $past(i_clk_time[15:0], 2);
   endproperty
   a_sample: assert property (p_sample) // [R20]
      else $error("sampled time word wrong");

   property p_load_dis;
      @(posedge i_clk) disable iff (i_rst)
      i_cmd.trig_ld |=> o_trig_disable
         && o_trig_dis_idx == $past(i_cmd.sel)
         && mode_r == pts_pkg::M_TWR;
   endproperty
   a_load_dis: assert property (p_load_dis) // [R19]
      else $error("trigger load did not disable");

   property p_err_src;
      @(posedge i_clk) disable iff (i_rst)
      1'b1 |=> (err_r & ~$past(err_r) & ~$past(late_ok)) == '0;
   endproperty
   a_err_src: assert property (p_err_src) // [R17]
      else $error("error flag set without notify");

   property p_err_clr;
      @(posedge i_clk) disable iff (i_rst)
      cmd_rearm && !late_ok[i_cmd.sel] |=> !err_r[$past(i_cmd.sel)];
   endproperty
   a_err_clr: assert property (p_err_clr) // [R16]
      else $error("error flag not cleared on re-arm");

   property p_clk_set;
      @(posedge i_clk) disable iff (i_rst)
      i_cmd.clk_set |=> o_clk_set && o_clk_set_val == $past(load_r);
   endproperty
   a_clk_set: assert property (p_clk_set) // [R21]
      else $error("clock set value wrong");

   // an enable in mid-load ends it early and frees the port
   sequence s_load_cut;
      mode_r == pts_pkg::M_TWR && i_cmd.trig_en && !any_cmd;
   endsequence

   property p_load_cut;
      @(posedge i_clk) disable iff (i_rst)
      s_load_cut |=> mode_r == pts_pkg::M_CLK
         && wr_ptr_r == pts_pkg::PTR_RST;
   endproperty
   a_load_cut: assert property (p_load_cut) // [R19]
      else $error("trigger load not ended by enable");
endmodule

// ==== tb/tb_ptp_time_data_status_regs.sv ====
// Purpose: self-checking bench for the time-data and status registers
// Assumes: one 25 MHz clock, read data stands the cycle after the strobe
// Notes: table rows cover status mirrors, hand tests cover sequences
`timescale 1ns/100ps
module tb_ptp_time_data_status_regs;
   // -----------------------------------------------------------------
   // stimulus table and command codes
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] avail;
      logic [7:0] act;
      logic [15:0] sts;
      logic [15:0] tsts;
      logic irq;
   } ptdsr_row_t;
   localparam logic [5:0] C_TRD = 6'h20;
   localparam logic [5:0] C_TLD = 6'h10;
   localparam logic [5:0] C_TEN = 6'h08;
   localparam logic [5:0] C_TDIS = 6'h04;
   localparam logic [5:0] C_SMP = 6'h02;
   localparam logic [5:0] C_SET = 6'h01;

   logic i_clk;
   logic i_rst;
   pts_pkg::pts_bus_t i_bus;
   pts_pkg::pts_cmd_t i_cmd;
   logic [63:0] i_clk_time;
   logic i_tx_avail, i_rx_avail, i_ev_avail;
   logic [7:0] i_trig_fire, i_trig_late, i_trig_active, i_trig_notify;
   logic [15:0] o_rdata, o_trig_wdata;
   logic o_clk_set, o_trig_wr, o_trig_disable, o_irq;
   logic [63:0] o_clk_set_val;
   logic [2:0] o_trig_widx, o_trig_wfield, o_trig_dis_idx;
   int n_fail;
   int total_checks;
   ptdsr_row_t rows[5];

   pts_regs u_pts_regs (
      .i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
      .i_cmd(i_cmd), .i_clk_time(i_clk_time), .o_clk_set(o_clk_set),
      .o_clk_set_val(o_clk_set_val), .i_tx_avail(i_tx_avail),
      .i_rx_avail(i_rx_avail), .i_ev_avail(i_ev_avail),
      .i_trig_fire(i_trig_fire), .i_trig_late(i_trig_late),
      .i_trig_active(i_trig_active), .i_trig_notify(i_trig_notify),
      .o_trig_wr(o_trig_wr), .o_trig_widx(o_trig_widx),
      .o_trig_wfield(o_trig_wfield), .o_trig_wdata(o_trig_wdata),
      .o_trig_disable(o_trig_disable), .o_trig_dis_idx(o_trig_dis_idx),
      .o_irq(o_irq)
   );

   // free-running 40 ns clock
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   // -----------------------------------------------------------------
   // compare and bus tasks
   // -----------------------------------------------------------------
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one-cycle write strobe; #1 lets the answering flops settle
   task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk);
      i_bus.wr <= 1'b0;
      #1;
   endtask

   // data stands only in the cycle after the strobe, so look there
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
      @(posedge i_clk);
      i_bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk);
      i_bus.rd <= 1'b0;
      #1;
      chk16(o_rdata, exp);
   endtask

   task automatic do_cmd(input logic [2:0] sel, input logic [5:0] bits);
      @(posedge i_clk);
      i_cmd <= {sel, bits};
      @(posedge i_clk);
      i_cmd <= '0;
      #1;
   endtask

   // which = 0 pulses fire, otherwise late
   task automatic pulse(input int which, input logic [7:0] m);
      @(posedge i_clk);
      if (which == 0) begin
         i_trig_fire <= m;
      end else begin
         i_trig_late <= m;
      end
      @(posedge i_clk);
      i_trig_fire <= 8'h00;
      i_trig_late <= 8'h00;
      #1;
   endtask

   task automatic give_verdict;
      $display("checks=%0d failures=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // watchdog: the sequence needs well under 1000 cycles
   initial begin
      #(40 * 4000);
      n_fail++;
      give_verdict();
   end

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      n_fail = 0;
      total_checks = 0;
      i_rst = 1'b1;
      i_bus = '0;
      i_cmd = '0;
      i_clk_time = 64'h0;
      {i_tx_avail, i_rx_avail, i_ev_avail} = 3'b000;
      i_trig_fire = 8'h00;
      i_trig_late = 8'h00;
      i_trig_active = 8'h00;
      i_trig_notify = 8'h14;
      rows = '{'{3'b000, 8'h00, 16'h000F, 16'h0000, 1'b0},
               '{3'b100, 8'h01, 16'h080F, 16'h0001, 1'b1},
               '{3'b010, 8'h80, 16'h040F, 16'h4000, 1'b1},
               '{3'b001, 8'h55, 16'h010F, 16'h1111, 1'b1},
               '{3'b111, 8'hFF, 16'h0D0F, 16'h5555, 1'b1}};
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      rd_chk(pts_pkg::A_STS, 16'h0000);
      chk1(o_irq, 1'b0);
      reg_wr(pts_pkg::A_STS, 16'hFFFF);
      // mirrors, enables and reserved bits, one row at a time
      foreach (rows[i]) begin
         @(posedge i_clk);
         {i_tx_avail, i_rx_avail, i_ev_avail} <= rows[i].avail;
         i_trig_active <= rows[i].act;
         rd_chk(pts_pkg::A_STS, rows[i].sts);
         rd_chk(pts_pkg::A_TSTS, rows[i].tsts);
         chk1(o_irq, rows[i].irq);
      end
      @(posedge i_clk);
      {i_tx_avail, i_rx_avail, i_ev_avail} <= 3'b100;
      i_trig_active <= 8'h00;
      reg_wr(pts_pkg::A_STS, 16'h0007);
      chk1(o_irq, 1'b0);
      reg_wr(pts_pkg::A_TSTS, 16'hFFFF);
      rd_chk(pts_pkg::A_TSTS, 16'h0000);
      rd_chk(5'h1F, 16'h0000);
      @(posedge i_clk);
      i_tx_avail <= 1'b0;
      // fired flag: set on notify, cleared by the status read
      reg_wr(pts_pkg::A_STS, 16'h0002);
      pulse(0, 8'h04);
      chk1(o_irq, 1'b1);
      rd_chk(pts_pkg::A_STS, 16'h0202);
      chk1(o_irq, 1'b0);
      rd_chk(pts_pkg::A_STS, 16'h0002);
      pulse(0, 8'h08);
      rd_chk(pts_pkg::A_STS, 16'h0002);
      // late programming errors, cleared by disable and re-arm
      pulse(1, 8'h50);
      rd_chk(pts_pkg::A_TSTS, 16'h0200);
      do_cmd(3'd4, C_TDIS);
      rd_chk(pts_pkg::A_TSTS, 16'h0000);
      pulse(1, 8'h10);
      rd_chk(pts_pkg::A_TSTS, 16'h0200);
      do_cmd(3'd4, C_TEN);
      rd_chk(pts_pkg::A_TSTS, 16'h0000);
      // trigger load of all six fields, then one extra write that lands in the clock load words
      do_cmd(3'd5, C_TLD);
      chk1(o_trig_disable, 1'b1);
      chk16({13'h0, o_trig_dis_idx}, 16'h0005);
      for (int k = 0; k < 6; k++) begin
         reg_wr(pts_pkg::A_TDR, 16'hA000 + 16'(k));
         chk1(o_trig_wr, 1'b1);
         chk16({10'h0, o_trig_widx, o_trig_wfield},
            {10'h0, 3'd5, 3'(k)});
         chk16(o_trig_wdata, 16'hA000 + 16'(k));
      end
      reg_wr(pts_pkg::A_TDR, 16'hBEEF);
      chk1(o_trig_wr, 1'b0);
      do_cmd(3'd5, C_TRD);
      for (int k = 0; k < 6; k++) begin
         rd_chk(pts_pkg::A_TDR, 16'hA000 + 16'(k));
      end
      rd_chk(pts_pkg::A_TDR, 16'h0000);
      // a load cut short by an enable hands the port back
      do_cmd(3'd2, C_TLD);
      reg_wr(pts_pkg::A_TDR, 16'h1234);
      chk1(o_trig_wr, 1'b1);
      do_cmd(3'd2, C_TEN);
      reg_wr(pts_pkg::A_TDR, 16'h5678);
      chk1(o_trig_wr, 1'b0);
      do_cmd(3'd2, C_TRD);
      rd_chk(pts_pkg::A_TDR, 16'h1234);
      // clock sample, read back low word first, then past the end
      @(posedge i_clk);
      i_clk_time <= 64'h1122_3344_5566_7788;
      do_cmd(3'd0, C_SMP);
      @(posedge i_clk);
      i_clk_time <= 64'h99AA_BBCC_DDEE_F011;
      rd_chk(pts_pkg::A_TDR, 16'h7788);
      rd_chk(pts_pkg::A_TDR, 16'h5566);
      rd_chk(pts_pkg::A_TDR, 16'h3344);
      rd_chk(pts_pkg::A_TDR, 16'h1122);
      rd_chk(pts_pkg::A_TDR, 16'h0000);
      // sample, then read in the very next cycle with no gap
      @(posedge i_clk);
      i_cmd <= {3'd0, C_SMP};
      @(posedge i_clk);
      i_cmd <= '0;
      i_bus <= '{addr: pts_pkg::A_TDR, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk);
      i_bus.rd <= 1'b0;
      #1;
      chk16(o_rdata, 16'hF011);
      do_cmd(3'd0, C_SMP);
      // clock load from four written words; a fifth is dropped
      for (int k = 0; k < 5; k++) begin
         reg_wr(pts_pkg::A_TDR,
            (k < 4) ? 16'h0A01 + 16'(k) : 16'hFFFF);
      end
      do_cmd(3'd0, C_SET);
      chk1(o_clk_set, 1'b1);
      chk64(o_clk_set_val, 64'h0A04_0A03_0A02_0A01);
      @(posedge i_clk);
      #1;
      chk1(o_clk_set, 1'b0);
      // reset in mid-run clears the enables again
      @(posedge i_clk);
      i_rst <= 1'b1;
      @(posedge i_clk);
      i_rst <= 1'b0;
      rd_chk(pts_pkg::A_STS, 16'h0000);
      give_verdict();
   end
endmodule
